// ===== hdl/seep_map.svh
// Purpose: Constants of the serial memory command port (opcodes, field sizes, timing counts).
// Assumes: Included by bare name; definitions only.
// Notes:   Times are kept in their printed unit and converted to clock counts here.
`ifndef SEEP_MAP_SVH
`define SEEP_MAP_SVH

// ==========================================================
// Opcodes and extended sub-commands
`define SEEP_OP_READ      2'b10
`define SEEP_OP_CLEAR     2'b11
`define SEEP_OP_PROG      2'b01
`define SEEP_OP_EXT       2'b00
`define SEEP_SUB_UNLOCK   2'b11
`define SEEP_SUB_LOCK     2'b00
`define SEEP_SUB_CLRALL   2'b10
`define SEEP_SUB_FILL     2'b01

// ==========================================================
// Field sizes (last bit index of each field)
`define SEEP_OP_LAST      5'h01
`define SEEP_ADDR_LAST_W  5'h05
`define SEEP_ADDR_LAST_B  5'h06
`define SEEP_DATA_LAST_W  5'h0F
`define SEEP_DATA_LAST_B  5'h07
`define SEEP_WORDS        64
`define SEEP_LAST_WORD    6'h3F
`define SEEP_ERASED       16'hFFFF

// ==========================================================
// Timing
`define SEEP_SYS_PERIOD_NS   100
`define SEEP_CYCLE_TIME_MS   5
`define SEEP_CYCLE_CNT       ((`SEEP_CYCLE_TIME_MS * 1000000) / `SEEP_SYS_PERIOD_NS)

`endif

// ===== hdl/seep_pkg.sv
// Purpose: Types shared by the serial memory command port modules.
// Assumes: Constants live in seep_map.svh.
// Notes:   State codes are written out so waveforms read the same in every tool.
package seep_pkg;

  // ==========================================================
  // Link-side decoder states
  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_OP   = 3'b001,
    L_ADDR = 3'b010,
    L_DATA = 3'b011,
    L_READ = 3'b100,
    L_DONE = 3'b101
  } seep_link_st_t;

  // ==========================================================
  // Self-timed cycle states
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_CLEAR = 3'b001,
    S_STORE = 3'b010,
    S_SWEEP = 3'b011,
    S_WAIT  = 3'b100
  } seep_cyc_st_t;

  // ==========================================================
  // Array-changing command kinds
  typedef enum logic [1:0] {
    K_PROG   = 2'b00,
    K_CLEAR  = 2'b01,
    K_CLRALL = 2'b10,
    K_FILL   = 2'b11
  } seep_kind_t;

endpackage

// ===== hdl/seep_mem_if.sv
// Purpose: Carrier between the command port and its storage array.
// Assumes: Write side on the system clock, read side on the serial clock.
// Notes:   No clocks inside; each side brings its own.
`timescale 1ns/1ps
interface seep_mem_if;
  logic        wrEn;
  logic [1:0]  wrByteEn;
  logic [5:0]  wrIdx;
  logic [15:0] wrData;
  logic [5:0]  rdIdx;
  logic [15:0] rdData;

  modport writer (output wrEn, output wrByteEn, output wrIdx, output wrData, output rdIdx, input rdData);
  modport array  (input wrEn, input wrByteEn, input wrIdx, input wrData, input rdIdx, output rdData);
endinterface

// ===== hdl/seep_mem.sv
// Purpose: 64 x 16 storage array with a system-clock write port and a serial-clock read port.
// Assumes: Writer never writes while the reader streams (host avoids reads while busy by protocol; the port does not block them).
// Notes:   Read data come out of a register on every rising serial clock edge.
`timescale 1ns/1ps
`include "seep_map.svh"
module seep_mem
(
  input  wire logic  wrClk,
  input  wire logic  rdClk,
  seep_mem_if.array  mem
);

  logic [15:0] cellArray [0:`SEEP_WORDS-1];

  // ==========================================================
  // Write port: two lanes so byte organisation touches half a word
  always_ff @(posedge wrClk)
  begin
    for (int lane = 0; lane < 2; lane++)
    begin
      if (mem.wrEn && mem.wrByteEn[lane])
        cellArray[mem.wrIdx][lane*8 +: 8] <= mem.wrData[lane*8 +: 8];
    end
  end

  // ==========================================================
  // Read port on the link clock
  always_ff @(posedge rdClk)
  begin
    mem.rdData <= cellArray[mem.rdIdx];
  end

endmodule

// ===== hdl/seep_timer.sv
// Purpose: Down-counter timing one self-timed program or clear cycle.
// Assumes: One-cycle start pulse on the system clock.
// Notes:   A restart while running reloads the count.
`timescale 1ns/1ps
module seep_timer
#(
  parameter int unsigned COUNT = 50000
)
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      running
);

  localparam int unsigned W = $clog2(COUNT + 1);

  logic [W-1:0] remain_ff;

  // ==========================================================
  // Count down to zero after each start
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      remain_ff <= '0;
    else if (start)
      remain_ff <= W'(COUNT);
    else if (remain_ff != '0)
      remain_ff <= remain_ff - W'(1);
  end

  assign running = (remain_ff != '0);

endmodule

// ===== hdl/seep_port.sv
// Purpose: Three-wire serial command port of a 1024-bit nonvolatile array (64 x 16 or 128 x 8).
// Assumes: sys_clk at 10 MHz drives self-timed cycles; serialClockIn may stop between frames.
// Notes:   Width strap is quasi-static; it is synchronised on sys_clk and read as a level by the link.
`timescale 1ns/1ps
`include "seep_map.svh"

// Overview of operation
// - Frame is start one, two-bit opcode, address, then data for writes.
// - Header is nine bits in word mode, ten bits in byte mode.
// - Opcode, address and data bits are sampled on rising serial clock.
// - Output floats except for read data or busy/ready status.
// - After a cycle starts and select rises, output shows low busy, high ready.
// - A one shifted in while selected returns the output to float.
// - Status may be dismissed only when ready; busy attempts change nothing.
// - Opcode 10 reads, 11 clears, 01 programs, 00 is extended group.
// - Read sends one dummy zero, then the word most significant bit first.
// - Read data bits change on the rising serial clock edge.
// - Continued clocking streams next words, wrapping last address to zero.
// - Only the first streamed word is preceded by the dummy zero.
// - Starts locked; unlock command needed before any program or clear.
// - Unlock stays set until lock command or power removal.
// - Reads return data whatever the lock state.
// - Falling select after a change command starts the self-timed cycle.
// - Self-timed cycle completes with no further serial clocks.
// - Single program clears the location before storing.
// - Single clear leaves every bit of the location at one.
// - Clear-all sets the whole array to ones in one cycle.
// - Fill-all writes the data word everywhere in one cycle.
// - Every self-timed cycle ends within 5 ms, then ready.
// - Width strap high selects 16-bit words, low 8-bit, floating 16-bit.
module seep_port
#(
  parameter int unsigned CYCLE_COUNT = `SEEP_CYCLE_CNT
)
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic serialClockIn,
  input  wire logic chipSelect,
  input  wire logic serialIn,
  input  wire logic widthSelect,
  output logic      serialOut,
  output logic      serialOutEn,
  output logic      busy
);

  import seep_pkg::*;

  // ==========================================================
  // Decoding helpers shared by the link side and the cycle engine

  // Sub-command sits in the two leading address bits
  function automatic logic [1:0] subOf(input logic [6:0] a, input logic wide);
    subOf = wide ? a[5:4] : a[6:5];
  endfunction

  // Word index of an address; byte addresses pair two to a word
  function automatic logic [5:0] wordIdx(input logic [6:0] a, input logic wide);
    wordIdx = wide ? a[5:0] : a[6:1];
  endfunction

  // Byte lanes touched; even byte address is the upper lane
  function automatic logic [1:0] laneOf(input logic [6:0] a, input logic wide);
    laneOf = wide ? 2'b11 : (a[0] ? 2'b01 : 2'b10);
  endfunction

  // Left-align the addressed word or byte for shifting out
  function automatic logic [15:0] alignWord(input logic [15:0] w, input logic [6:0] a, input logic wide);
    alignWord = wide ? w : (a[0] ? {w[7:0], 8'h00} : {w[15:8], 8'h00});
  endfunction

  // ==========================================================
  // Declarations
  seep_mem_if    memBus ();
  logic [2:0]    selSync_ff;
  logic          sel_ff;
  logic [2:0]    widthSync_ff;
  logic          wide_ff;
  logic [2:0]    reqSync_ff;
  logic          ack_ff;
  logic [2:0]    dismissSync_ff;
  logic          dismissSeen_ff;
  seep_cyc_st_t  cycState_ff;
  seep_kind_t    runKind_ff;
  logic [5:0]    runIdx_ff;
  logic [1:0]    runLane_ff;
  logic [15:0]   runData_ff;
  logic          statusArm_ff;
  logic          selFall;
  logic          reqNew;
  logic          dismissNew;
  logic          startCycle;
  logic          timerRun;
  logic          linkRst;
  seep_link_st_t linkState_ff;
  logic [4:0]    bitCnt_ff;
  logic [1:0]    op_ff;
  logic [6:0]    addr_ff;
  logic [15:0]   inShift_ff;
  logic [15:0]   outShift_ff;
  logic [6:0]    readAddr_ff;
  logic          linkDrive_ff;
  seep_kind_t    cmdKind_ff;
  logic [6:0]    cmdAddr_ff;
  logic [15:0]   cmdData_ff;
  logic          reqTgl_ff;
  logic          unlock_ff;
  logic          dismissTgl_ff;
  logic [6:0]    hdrAddr;
  logic [1:0]    hdrSub;
  logic          addrLast;
  logic          dataLast;
  logic          cmdFire;
  logic [4:0]    addrLastIdx;
  logic [4:0]    dataLastIdx;

  // ==========================================================
  // Link side: frame decoding on the serial clock

  // Select low clears the frame logic at once, mid-frame or not
  assign linkRst = rst | ~chipSelect;

  // Field lengths follow the width strap
  assign addrLastIdx = wide_ff ? `SEEP_ADDR_LAST_W : `SEEP_ADDR_LAST_B;
  assign dataLastIdx = wide_ff ? `SEEP_DATA_LAST_W : `SEEP_DATA_LAST_B;
  assign hdrAddr     = {addr_ff[5:0], serialIn};
  assign hdrSub      = subOf(hdrAddr, wide_ff);
  assign addrLast    = (linkState_ff == L_ADDR) && (bitCnt_ff == addrLastIdx);
  assign dataLast    = (linkState_ff == L_DATA) && (bitCnt_ff == dataLastIdx);

  // Frame state machine; every bit is taken on the rising edge
  always_ff @(posedge serialClockIn or posedge linkRst)
  begin
    if (linkRst)
    begin
      linkState_ff <= L_IDLE;
      bitCnt_ff    <= 5'h00;
      op_ff        <= 2'b00;
      addr_ff      <= 7'h00;
      inShift_ff   <= 16'h0000;
    end
    else
    begin
      case (linkState_ff)
        L_IDLE:
        begin
          // Zeros before the start bit are idle clocks
          if (serialIn)
          begin
            linkState_ff <= L_OP;
            bitCnt_ff    <= 5'h00;
          end
        end
        L_OP:
        begin
          op_ff     <= {op_ff[0], serialIn};
          bitCnt_ff <= bitCnt_ff + 5'h01;
          if (bitCnt_ff == `SEEP_OP_LAST)
          begin
            linkState_ff <= L_ADDR;
            bitCnt_ff    <= 5'h00;
          end
        end
        L_ADDR:
        begin
          addr_ff   <= hdrAddr;
          bitCnt_ff <= bitCnt_ff + 5'h01;
          if (addrLast)
          begin
            bitCnt_ff <= 5'h00;
            if (op_ff == `SEEP_OP_READ)
              linkState_ff <= L_READ;
            else if ((op_ff == `SEEP_OP_PROG) || ((op_ff == `SEEP_OP_EXT) && (hdrSub == `SEEP_SUB_FILL)))
              linkState_ff <= L_DATA;
            else
              linkState_ff <= L_DONE;
          end
        end
        L_DATA:
        begin
          inShift_ff <= {inShift_ff[14:0], serialIn};
          bitCnt_ff  <= bitCnt_ff + 5'h01;
          if (dataLast)
            linkState_ff <= L_DONE;
        end
        L_READ:
        begin
          // Zero means the next edge loads a fresh word
          bitCnt_ff <= (bitCnt_ff == 5'h00) ? dataLastIdx : (bitCnt_ff - 5'h01);
        end
        default:
        begin
          // Surplus clocks after a complete frame are ignored
          linkState_ff <= linkState_ff;
        end
      endcase
    end
  end

  // Read address: header address on its last bit, streaming address otherwise
  assign memBus.rdIdx = wordIdx(addrLast ? hdrAddr : readAddr_ff, wide_ff);

  // Read shifter; output bit is the top of a flip-flop so it changes on the rising edge
  always_ff @(posedge serialClockIn or posedge linkRst)
  begin
    if (linkRst)
    begin
      linkDrive_ff <= 1'b0;
      outShift_ff  <= 16'h0000;
      readAddr_ff  <= 7'h00;
    end
    else if (addrLast && (op_ff == `SEEP_OP_READ))
    begin
      linkDrive_ff <= 1'b1;
      outShift_ff  <= 16'h0000;
      readAddr_ff  <= hdrAddr;
    end
    else if (linkState_ff == L_READ)
    begin
      if (bitCnt_ff == 5'h00)
      begin
        // Later words load straight after the last bit, no dummy again
        outShift_ff <= alignWord(memBus.rdData, readAddr_ff, wide_ff);
        readAddr_ff <= wide_ff ? {1'b0, readAddr_ff[5:0] + 6'h01} : (readAddr_ff + 7'h01);
      end
      else
      begin
        outShift_ff <= {outShift_ff[14:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // Command hold: survives deselect so the cycle engine can pick it up

  // A complete array-changing frame; only accepted while unlocked
  assign cmdFire = dataLast || (addrLast && ((op_ff == `SEEP_OP_CLEAR) ||
                   ((op_ff == `SEEP_OP_EXT) && (hdrSub == `SEEP_SUB_CLRALL))));

  // Lock latch is cleared by the lock command, or by reset standing in for power removal
  always_ff @(posedge serialClockIn or posedge rst)
  begin
    if (rst)
      unlock_ff <= 1'b0;
    else if (addrLast && (op_ff == `SEEP_OP_EXT) && (hdrSub == `SEEP_SUB_UNLOCK))
      unlock_ff <= 1'b1;
    else if (addrLast && (op_ff == `SEEP_OP_EXT) && (hdrSub == `SEEP_SUB_LOCK))
      unlock_ff <= 1'b0;
  end

  // Captured command and its request toggle
  always_ff @(posedge serialClockIn or posedge rst)
  begin
    if (rst)
    begin
      cmdKind_ff <= K_PROG;
      cmdAddr_ff <= 7'h00;
      cmdData_ff <= 16'h0000;
      reqTgl_ff  <= 1'b0;
    end
    else if (cmdFire && unlock_ff)
    begin
      if (dataLast)
        cmdKind_ff <= (op_ff == `SEEP_OP_PROG) ? K_PROG : K_FILL;
      else
        cmdKind_ff <= (op_ff == `SEEP_OP_CLEAR) ? K_CLEAR : K_CLRALL;
      cmdAddr_ff <= dataLast ? addr_ff : hdrAddr;
      cmdData_ff <= {inShift_ff[14:0], serialIn};
      reqTgl_ff  <= ~reqTgl_ff;
    end
  end

  // Every start bit is also a dismiss request for the status output
  always_ff @(posedge serialClockIn or posedge rst)
  begin
    if (rst)
      dismissTgl_ff <= 1'b0;
    else if ((linkState_ff == L_IDLE) && serialIn && chipSelect)
      dismissTgl_ff <= ~dismissTgl_ff;
  end

  // ==========================================================
  // System side: pin synchronisers and crossings

  // Select and strap pass three flops; a change counts when the last two agree
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      selSync_ff   <= 3'b000;
      sel_ff       <= 1'b0;
      widthSync_ff <= 3'b111;
      wide_ff      <= 1'b1;
    end
    else
    begin
      selSync_ff   <= {selSync_ff[1:0], chipSelect};
      widthSync_ff <= {widthSync_ff[1:0], widthSelect};
      if (selSync_ff[1] == selSync_ff[2])
        sel_ff <= selSync_ff[2];
      if (widthSync_ff[1] == widthSync_ff[2])
        wide_ff <= widthSync_ff[2];
    end
  end

  assign selFall = sel_ff && !selSync_ff[1] && !selSync_ff[2];

  // Toggles from the link pass three flops; a toggle is older than the synced select edge it pairs with
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      reqSync_ff     <= 3'b000;
      dismissSync_ff <= 3'b000;
      ack_ff         <= 1'b0;
      dismissSeen_ff <= 1'b0;
    end
    else
    begin
      reqSync_ff     <= {reqSync_ff[1:0], reqTgl_ff};
      dismissSync_ff <= {dismissSync_ff[1:0], dismissTgl_ff};
      dismissSeen_ff <= dismissSync_ff[2];
      if (selFall)
        ack_ff <= reqSync_ff[2];
    end
  end

  // A toggle counts once the last two flops agree
  assign reqNew     = (reqSync_ff[1] == reqSync_ff[2]) && (reqSync_ff[2] != ack_ff);
  assign dismissNew = (dismissSync_ff[1] == dismissSync_ff[2]) && (dismissSync_ff[2] != dismissSeen_ff);
  // Requests arriving during a running cycle are consumed and dropped
  assign startCycle = selFall && reqNew && (cycState_ff == S_IDLE);

  // ==========================================================
  // Self-timed cycle engine, independent of the serial clock
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cycState_ff <= S_IDLE;
      runKind_ff  <= K_PROG;
      runIdx_ff   <= 6'h00;
      runLane_ff  <= 2'b00;
      runData_ff  <= 16'h0000;
    end
    else
    begin
      case (cycState_ff)
        S_IDLE:
        begin
          if (startCycle)
          begin
            runKind_ff  <= cmdKind_ff;
            runData_ff  <= wide_ff ? cmdData_ff : {cmdData_ff[7:0], cmdData_ff[7:0]};
            runLane_ff  <= laneOf(cmdAddr_ff, wide_ff);
            if ((cmdKind_ff == K_CLRALL) || (cmdKind_ff == K_FILL))
            begin
              runIdx_ff   <= 6'h00;
              cycState_ff <= S_SWEEP;
            end
            else
            begin
              runIdx_ff   <= wordIdx(cmdAddr_ff, wide_ff);
              cycState_ff <= S_CLEAR;
            end
          end
        end
        S_CLEAR:
        begin
          cycState_ff <= (runKind_ff == K_PROG) ? S_STORE : S_WAIT;
        end
        S_STORE:
        begin
          cycState_ff <= S_WAIT;
        end
        S_SWEEP:
        begin
          runIdx_ff <= runIdx_ff + 6'h01;
          if (runIdx_ff == `SEEP_LAST_WORD)
            cycState_ff <= S_WAIT;
        end
        S_WAIT:
        begin
          if (!timerRun)
            cycState_ff <= S_IDLE;
        end
        default:
        begin
          cycState_ff <= S_IDLE;
        end
      endcase
    end
  end

  // Cycle length is fixed by the timer, not by how many words were touched
  seep_timer #(
    .COUNT   (CYCLE_COUNT)
  ) u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (startCycle),
    .running (timerRun)
  );

  // Array writes: clear steps write ones, store and fill write the captured word
  assign memBus.wrEn     = (cycState_ff == S_CLEAR) || (cycState_ff == S_STORE) || (cycState_ff == S_SWEEP);
  assign memBus.wrIdx    = runIdx_ff;
  assign memBus.wrByteEn = (cycState_ff == S_SWEEP) ? 2'b11 : runLane_ff;
  assign memBus.wrData   = ((cycState_ff == S_CLEAR) || ((cycState_ff == S_SWEEP) && (runKind_ff == K_CLRALL)))
                           ? `SEEP_ERASED : runData_ff;

  seep_mem u_mem (
    .wrClk (sys_clk),
    .rdClk (serialClockIn),
    .mem   (memBus)
  );

  // ==========================================================
  // Status output: armed by each cycle, shown while selected

  // Dismissal while busy is dropped, so status survives stray start bits
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      statusArm_ff <= 1'b0;
    else if (startCycle)
      statusArm_ff <= 1'b1;
    else if (dismissNew && (cycState_ff == S_IDLE))
      statusArm_ff <= 1'b0;
  end

  // Read data take priority; status shows low busy, high ready
  assign busy        = (cycState_ff != S_IDLE);
  // Raw select turns status off at once; the synced copy alone would lag four clocks
  assign serialOutEn = linkDrive_ff | (statusArm_ff & sel_ff & chipSelect);
  assign serialOut   = linkDrive_ff ? outShift_ff[15] : !busy;

endmodule

// ===== sim/seep_port_asserts.sv
// Purpose: Pin-level checks of the serial command port.
// Assumes: The host never reads while a cycle runs.
// Notes:   All checks on sys_clk; link bit timing is judged by the bench.
`timescale 1ns/1ps
module seep_port_asserts
#(
  parameter int unsigned CYCLE_COUNT = 100
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic serialClockIn,
  input wire logic chipSelect,
  input wire logic serialIn,
  input wire logic widthSelect,
  input wire logic serialOut,
  input wire logic serialOutEn,
  input wire logic busy
);
  // ==========================================================
  // Busy length counter
  int unsigned busyCnt_ff;

  // Cleared when idle, so each cycle is measured alone
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      busyCnt_ff <= 32'h0;
    else
      busyCnt_ff <= busy ? busyCnt_ff + 32'h1 : 32'h0;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Checks
  AST_UNSEL_FLOAT: assert property (!chipSelect |-> !serialOutEn)
    else $error("output driven while deselected");
  AST_BUSY_LOW: assert property (serialOutEn && busy |-> !serialOut)
    else $error("status not low while busy");
  AST_READY_HIGH: assert property (chipSelect && serialOutEn && $fell(busy) |-> ##[0:1] serialOut)
    else $error("status not high after cycle end");
  AST_CYCLE_MAX: assert property (busyCnt_ff <= CYCLE_COUNT + 1)
    else $error("cycle runs too long");
  AST_CYCLE_MIN: assert property ($fell(busy) |-> busyCnt_ff + 1 >= CYCLE_COUNT)
    else $error("cycle ended early");
  AST_START_DESEL: assert property ($rose(busy) |-> !chipSelect && !$past(chipSelect))
    else $error("cycle started while selected");
  AST_BUSY_KEEPS: assert property (chipSelect && serialOutEn && busy |=> serialOutEn || !chipSelect)
    else $error("status dismissed while busy");
  AST_STATUS_SEL: assert property ($rose(serialOutEn) && busy |-> chipSelect && $past(chipSelect, 2))
    else $error("status shown without select");
endmodule

bind seep_port seep_port_asserts #(.CYCLE_COUNT(CYCLE_COUNT)) i_seep_port_asserts (
  .sys_clk(sys_clk), .rst(rst), .serialClockIn(serialClockIn), .chipSelect(chipSelect),
  .serialIn(serialIn), .widthSelect(widthSelect), .serialOut(serialOut),
  .serialOutEn(serialOutEn), .busy(busy));

// ===== sim/seep_host_model.sv
// Purpose: Host side of the serial link: select, clock and data in.
// Assumes: Caller holds select low long enough to start a cycle.
// Notes:   Clock runs at 32 ns only inside frames and is parked low between.
`timescale 1ns/1ps
module seep_host_model
(
  output logic      serialClockIn,
  output logic      chipSelect,
  output logic      serialIn,
  input  wire logic serialOut,
  input  wire logic serialOutEn
);
  logic lastBit;

  // ==========================================================
  // Idle levels
  initial
  begin
    serialClockIn = 1'h0;
    chipSelect = 1'h0;
    serialIn = 1'h0;
    lastBit = 1'h0;
  end

  // Select change, settled before anything else moves
  task automatic sel(input logic v);
    chipSelect = v;
    #20;
  endtask

  // Shifts n bits out, MSB first; a floating output reads as the inverse of the last bit
  task automatic shift(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = 64'h0;
    for (int i = n - 1; i >= 0; i--)
    begin
      serialIn = tx[i];
      #16 serialClockIn = 1'h1;
      #8 lastBit = serialOutEn ? serialOut : ~lastBit;
      rx = {rx[62:0], lastBit};
      #8 serialClockIn = 1'h0;
    end
  endtask
endmodule

// ===== sim/tb.sv
// Purpose: Self-checking bench of the serial command port.
// Assumes: Short cycle count; the host model makes the link clock.
// Notes:   Array starts unknown, so the first fill sets known data.
`timescale 1ns/1ps
module tb;
  localparam int unsigned CYC = 100;
  logic sys_clk, rst, widthSelect, serialClockIn, chipSelect, serialIn, serialOut, serialOutEn, busy;
  logic [63:0] rx;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;

  seep_port #(.CYCLE_COUNT(CYC)) i_seep_port (.sys_clk(sys_clk), .rst(rst), .serialClockIn(serialClockIn),
    .chipSelect(chipSelect), .serialIn(serialIn), .widthSelect(widthSelect), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .busy(busy));
  seep_host_model i_seep_host_model (.serialClockIn(serialClockIn), .chipSelect(chipSelect),
    .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn));

  // ==========================================================
  // Clock and timeout
  initial
  begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end

  // A hang counts as a mismatch and ends the run
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      summarize();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic clk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // One framed transfer, then deselect
  task automatic frame(input logic [63:0] bits, input int n);
    i_seep_host_model.sel(1'h1);
    i_seep_host_model.shift(bits, n, rx);
    i_seep_host_model.sel(1'h0);
    check(serialOutEn, 1'h0);
  endtask

  // Status polling through one cycle: low while busy, high when ready, then dismissed
  task automatic poll();
    i_seep_host_model.sel(1'h1);
    clk(6);
    check({serialOutEn, serialOut}, 2'h2);
    i_seep_host_model.shift(64'h1, 1, rx);
    // Brief select drop clears the decoder left waiting for an opcode; too short for the synced select
    i_seep_host_model.sel(1'h0);
    i_seep_host_model.sel(1'h1);
    clk(6);
    check(serialOutEn, 1'h1);
    for (int k = 0; k < 200 && busy !== 1'h0; k++)
      clk(1);
    clk(2);
    check({busy, serialOutEn, serialOut}, 3'h3);
    i_seep_host_model.shift(64'h1, 1, rx);
    clk(6);
    check(serialOutEn, 1'h0);
    i_seep_host_model.sel(1'h0);
    clk(2);
  endtask

  // Command with deselect long enough to start a cycle
  task automatic cmd(input logic [63:0] bits, input int n, input logic expBusy);
    frame(bits, n);
    clk(8);
    check(busy, expBusy);
    if (expBusy)
      poll();
  endtask

  task automatic rd(input logic [63:0] hdr, input int hn, input int dn, input logic [63:0] exp);
    frame(hdr << dn, hn + dn);
    // Only the dummy bit and the data count; header clocks before the last see a floating line, and the last header clock carries the dummy
    check(rx & ((64'h1 << (dn + 1)) - 64'h1), exp);
    clk(2);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    rst = 1'h1;
    widthSelect = 1'h1;
    clk(16);
    rst = 1'h0;
    clk(10000);
    cmd({9'h145, 16'h1234}, 25, 1'h0);
    cmd(9'h130, 9, 1'h0);
    cmd({9'h110, 16'hA5C3}, 25, 1'h1);
    rd(9'h185, 9, 16, 64'h0A5C3);
    cmd({9'h17F, 16'h1234}, 25, 1'h1);
    rd(9'h1BF, 9, 32, {31'h0, 1'h0, 16'h1234, 16'hA5C3});
    cmd(9'h1C0, 9, 1'h1);
    rd(9'h180, 9, 16, 64'h0FFFF);
    widthSelect = 1'h0;
    clk(8);
    rd(10'h37F, 10, 16, 64'h034FF);
    widthSelect = 1'h1;
    clk(8);
    cmd({9'h140, 16'h0000} >> 10, 15, 1'h0);
    cmd(9'h120, 9, 1'h1);
    rd(9'h1BF, 9, 16, 64'h0FFFF);
    cmd(9'h100, 9, 1'h0);
    cmd({9'h17F, 16'h0000}, 25, 1'h0);
    rd(9'h1BF, 9, 16, 64'h0FFFF);
    summarize();
  end
endmodule
